// File: dv/mmvd_mem_model.sv
// memory model that answers byte reads one cycle late
`timescale 1ns/10ps
`default_nettype none
module mmvd_mem_model (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  output logic [7:0] mem_rdata
);
  initial mem_rdata = 8'h00;
  // content is a fixed pattern of the address
  always @(posedge clk) begin
    if (mem_read) begin
      mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c;
    end else begin
      // released bus flips so a stale byte is never mistaken for data
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // mmvd_mem_model
`default_nettype wire

// File: dv/tb_memory_map_vector_decode.sv
// self-checking bench for the memory map and vector decode
`timescale 1ns/10ps
`default_nettype none
module tb_memory_map_vector_decode;
  logic clk = 0;
  logic reset = 1;
  logic f = 0, r = 0, w = 0, pw = 0, xw = 0, prot = 0, ia = 0;
  logic [15:0] addr = 0, maddr, pc, pc_seen;
  logic [7:0] wd = 0, ps_q, xs_q, rdata, p, x;
  logic [4:0] slot = 0;
  logic [5:0] sel, blk;
  logic mrd, mwr, wblk, vbusy, pcl;
  int bad_count = 0, n_compared = 0, cyc = 0, pc_n = 0, j;
  int seed = 32'h2700_485b;
  logic [15:0] bnd [18] = '{16'h0000, 16'h003f, 16'h0040, 16'h7fff,
    16'h8000, 16'hbfff, 16'hc000, 16'hefff, 16'hf000, 16'hf3ff, 16'hf400,
    16'hf7ff, 16'hf800, 16'hfaff, 16'hfb00, 16'hfeff, 16'hff00, 16'hffff};
  logic [4:0] sl [4] = '{5'h02, 5'h03, 5'h1f, 5'h10};

  mmvd_decode dut (.clk(clk), .reset(reset), .cpu_addr(addr), .cpu_fetch(f),
    .cpu_read(r), .cpu_write(w), .prog_size_wr(pw), .expansion_size_wr(xw),
    .size_wdata(wd), .boot_protect_en(prot), .irq_accept(ia),
    .irq_slot(slot), .mem_rdata(rdata), .program_memory_size_select(ps_q),
    .expansion_ram_size_select(xs_q), .mem_addr(maddr), .mem_read(mrd),
    .mem_write(mwr), .sel_flash(sel[5]), .sel_vector(sel[4]),
    .sel_exp_ram(sel[3]), .sel_hsram(sel[2]), .sel_sfr(sel[1]),
    .sel_none(sel[0]), .flash_block(blk), .write_blocked(wblk),
    .vec_busy(vbusy), .pc_load(pcl), .program_counter(pc));
  mmvd_mem_model mem (.clk(clk), .mem_addr(maddr), .mem_read(mrd),
    .mem_rdata(rdata));

  always #12.5 clk = ~clk;

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pcl === 1'b1) begin
      pc_seen <= pc;
      pc_n <= pc_n + 1;
    end
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] bv(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  function automatic logic [5:0] area(logic [15:0] a, logic [7:0] ps,
                                      logic [7:0] xs);
    logic [15:0] lim;
    logic [5:0] s;
    lim = ps == 8'hcc ? 16'hbfff : ps == 8'hcf ? 16'hefff : 16'h7fff;
    s[5] = a <= lim;
    s[4] = a <= 16'h003f;
    s[3] = a <= 16'hf7ff && (xs == 8'h0a && a >= 16'hf400 ||
                             xs == 8'h08 && a >= 16'hf000);
    s[2] = a >= 16'hfb00 && a <= 16'hfeff;
    s[1] = a >= 16'hff00;
    s[0] = !(s[5] | s[3] | s[2] | s[1]);
    return s;
  endfunction

  task automatic op(logic [15:0] a, logic [2:0] frw);
    logic [5:0] e;
    logic bl;
    @(negedge clk);
    addr = a;
    {f, r, w} = frw;
    @(negedge clk);
    e = area(a, p, x);
    bl = prot & (a < 16'h1000);
    chk("mem_addr", a, maddr);
    chk("area", 16'(e), 16'(sel));
    chk("block", 16'(a[15:10]), 16'(blk));
    chk("mem_read", 16'(f | r), 16'(mrd));
    chk("mem_write", 16'(w & !bl), 16'(mwr));
    chk("write_blocked", 16'(w & bl), 16'(wblk));
    {f, r, w} = 3'b000;
  endtask

  task automatic setsz(logic [7:0] ps, logic [7:0] xs);
    @(negedge clk);
    pw = 1;
    wd = ps;
    @(negedge clk);
    pw = 0;
    xw = 1;
    wd = xs;
    @(negedge clk);
    xw = 0;
    chk("prog_size", 16'(ps), 16'(ps_q));
    chk("exp_size", 16'(xs), 16'(xs_q));
  endtask

  task automatic vec(logic [4:0] s, logic go);
    int n0;
    logic [15:0] ea;
    n0 = pc_n;
    ea = {10'h000, s, 1'b0};
    if (go) begin
      @(negedge clk);
      ia = 1;
      slot = s;
      @(negedge clk);
      // a second accept and a write while busy must both be refused
      slot = ~s;
      w = 1;
      @(negedge clk);
      ia = 0;
      w = 0;
      chk("mem_write", 16'h0000, 16'(mwr));
      chk("vec_busy", 16'h0001, 16'(vbusy));
    end
    repeat (40) if (pc_n == n0) @(negedge clk);
    chk("pc_load", 16'h0001, 16'(pc_n - n0));
    chk("program_counter", {bv(ea + 16'h0001), bv(ea)}, pc_seen);
    repeat (8) if (vbusy !== 1'b0) @(negedge clk);
    chk("vec_busy", 16'h0000, 16'(vbusy));
  endtask

  task automatic do_reset(int n);
    reset = 1;
    repeat (n) @(negedge clk);
    reset = 0;
    chk("prog_size", 16'h00cf, 16'(ps_q));
    chk("exp_size", 16'h000c, 16'(xs_q));
    chk("vec_busy", 16'h0001, 16'(vbusy));
    vec(5'h00, 1'b0);
    $display("test reset done");
  endtask

  initial begin
    do_reset(20);
    // map as it stands after reset, expansion ram switched off
    p = 8'hcf;
    x = 8'h0c;
    foreach (bnd[i]) op(bnd[i], 3'b010);
    $display("test reset map done");
    for (int c = 0; c < 3; c++) begin
      p = c == 0 ? 8'hcf : c == 1 ? 8'hcc : 8'hc8;
      x = c == 2 ? 8'h0a : 8'h08;
      setsz(p, x);
      foreach (bnd[i]) op(bnd[i], 3'b100);
      repeat (20) begin
        j = $random(seed);
        prot = j[31];
        // no debug session runs, so reserved ram is free to use
        op(16'($random(seed)), 3'(1 << (j[30:0] % 3)));
      end
      $display("test decode config %0d done", c);
    end
    prot = 1;
    op(16'h0fff, 3'b001);
    op(16'h1000, 3'b001);
    prot = 0;
    op(16'h0fff, 3'b001);
    op(16'h0080, 3'b010);
    op(16'h0084, 3'b010);
    op(16'h1080, 3'b010);
    op(16'h1084, 3'b010);
    $display("test boot protect done");
    foreach (sl[i]) vec(sl[i], 1'b1);
    vec(5'($random(seed)), 1'b1);
    $display("test vectors done");
    do_reset(3);
    tally_and_finish();
  end
endmodule // tb_memory_map_vector_decode
`default_nettype wire

// File: hw/mmvd_decode.sv
// 64 kb address map decode with size selection and vector fetch
`timescale 1ns/10ps
`default_nettype none
// Function
// - one flat 64 kb map, 16-bit address, for fetch and data access
// - size selects read cfh and 0ch after reset regardless of memory fitted
// - flash block number is address bits 15 to 10, block 00h at zero
// - last valid block is 1fh, 2fh or 3bh by capacity
// - flash decodes from zero to 7fffh, bfffh or efffh
// - program memory is addressed by the program counter on fetch
// - bytes 0000h to 003fh form the reset and interrupt vector table
// - reset or accepted interrupt branches to that source's 16-bit entry
// - each entry holds low byte at even, high byte at odd address
// - all reset causes share the entry at 0000h
// - writes to boot cluster zero can be blocked by a security setting
// - on reset the counter loads from bytes 0000h and 0001h
// - special function registers decode in ff00h to ffffh
// - 1 kb high-speed ram decodes at fb00h to feffh on every variant
module mmvd_decode (
  input wire logic clk,
  input wire logic reset,
  input wire logic [mmvd_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic cpu_fetch,
  input wire logic cpu_read,
  input wire logic cpu_write,
  input wire logic prog_size_wr,
  input wire logic expansion_size_wr,
  input wire logic [7:0] size_wdata,
  input wire logic boot_protect_en,
  input wire logic irq_accept,
  input wire logic [mmvd_pkg::SLOT_W-1:0] irq_slot,
  input wire logic [7:0] mem_rdata,
  output var logic [7:0] program_memory_size_select,
  output var logic [7:0] expansion_ram_size_select,
  output var logic [mmvd_pkg::ADDR_W-1:0] mem_addr,
  output var logic mem_read,
  output var logic mem_write,
  output var logic sel_flash,
  output var logic sel_vector,
  output var logic sel_exp_ram,
  output var logic sel_hsram,
  output var logic sel_sfr,
  output var logic sel_none,
  output var logic [mmvd_pkg::BLOCK_W-1:0] flash_block,
  output var logic write_blocked,
  output var logic vec_busy,
  output var logic pc_load,
  output var logic [mmvd_pkg::ADDR_W-1:0] program_counter
);
  import mmvd_pkg::*;

  logic vec_rd;
  logic [ADDR_W-1:0] vec_addr;
  logic vec_busy_c;
  logic [7:0] prog_size_nxt, exp_size_nxt;
  logic [ADDR_W-1:0] addr_c, flash_end_c, exp_base_c;
  logic exp_on_c;
  logic [BLOCK_W-1:0] block_c, block_last_c;
  logic rd_c, wr_c, fetch_c;
  logic flash_c, vector_c, exp_c, hsram_c, sfr_c, none_c, blocked_c;

  mmvd_vector_fetch u_vector_fetch (
    .clk(clk),
    .reset(reset),
    .irq_accept(irq_accept),
    .irq_slot(irq_slot),
    .mem_rdata(mem_rdata),
    .vec_rd(vec_rd),
    .vec_addr(vec_addr),
    .vec_busy(vec_busy_c),
    .pc_load(pc_load),
    .program_counter(program_counter)
  );

  // size selection registers
  always_comb begin
    prog_size_nxt = program_memory_size_select;
    exp_size_nxt = expansion_ram_size_select;
    if (prog_size_wr) begin
      prog_size_nxt = size_wdata;
    end
    if (expansion_size_wr) begin
      exp_size_nxt = size_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      program_memory_size_select <= PROG_SIZE_RESET;
      expansion_ram_size_select <= EXP_SIZE_RESET;
    end else begin
      program_memory_size_select <= prog_size_nxt;
      expansion_ram_size_select <= exp_size_nxt;
    end
  end

  // limits follow the programmed size; unknown codes fall back to 32 kb
  always_comb begin
    unique case (program_memory_size_select)
      PROG_SIZE_48K: begin
        flash_end_c = FLASH_END_48K;
        block_last_c = BLOCK_LAST_48K;
      end
      PROG_SIZE_60K: begin
        flash_end_c = FLASH_END_60K;
        block_last_c = BLOCK_LAST_60K;
      end
      default: begin
        flash_end_c = FLASH_END_32K;
        block_last_c = BLOCK_LAST_32K;
      end
    endcase
    exp_on_c = 1'b1;
    unique case (expansion_ram_size_select)
      EXP_SIZE_1K: exp_base_c = EXP_BASE_1K;
      EXP_SIZE_2K: exp_base_c = EXP_BASE_2K;
      default: begin
        exp_base_c = EXP_END;
        exp_on_c = 1'b0;
      end
    endcase
  end

  // address decode; vector fetch drives the address while requesting, cpu access held off while busy
  always_comb begin
    addr_c = vec_rd ? vec_addr : cpu_addr;
    fetch_c = !vec_busy_c && cpu_fetch;
    rd_c = vec_rd || fetch_c || (!vec_busy_c && cpu_read);
    wr_c = !vec_busy_c && cpu_write;
    block_c = addr_c[ADDR_W-1:BLOCK_LSB];
    flash_c = (addr_c <= flash_end_c) && (block_c <= block_last_c);
    vector_c = flash_c && (addr_c <= VECTOR_END);
    exp_c = exp_on_c && (addr_c >= exp_base_c) && (addr_c <= EXP_END);
    hsram_c = (addr_c >= HSRAM_BASE) && (addr_c <= HSRAM_END);
    sfr_c = (addr_c >= SFR_BASE);
    none_c = !(flash_c || exp_c || hsram_c || sfr_c);
    // flash writes reach mem_write unless protected and in boot blocks 00h to 03h, then flagged
    blocked_c = wr_c && flash_c && boot_protect_en
      && (block_c <= BOOT_CLUSTER_LAST_BLOCK);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_addr <= 16'h0000;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      sel_flash <= 1'b0;
      sel_vector <= 1'b0;
      sel_exp_ram <= 1'b0;
      sel_hsram <= 1'b0;
      sel_sfr <= 1'b0;
      sel_none <= 1'b0;
      flash_block <= 6'h00;
      write_blocked <= 1'b0;
      vec_busy <= 1'b1;
    end else begin
      mem_addr <= addr_c;
      mem_read <= rd_c;
      mem_write <= wr_c && !blocked_c;
      sel_flash <= flash_c;
      sel_vector <= vector_c;
      sel_exp_ram <= exp_c;
      sel_hsram <= hsram_c;
      sel_sfr <= sfr_c;
      sel_none <= none_c;
      flash_block <= block_c;
      write_blocked <= blocked_c;
      vec_busy <= vec_busy_c;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  size_reset_vals_a: assert property (
    $fell(reset) |-> program_memory_size_select == 8'hCF
      && expansion_ram_size_select == 8'h0C)
    else $error("size selects wrong after reset");
  size_write_a: assert property (
    prog_size_wr |=> program_memory_size_select == $past(size_wdata))
    else $error("program size select not updated");
  flash_limit_a: assert property (
    (program_memory_size_select == 8'hC8 && addr_c > 16'h7FFF)
      |=> !sel_flash)
    else $error("flash decoded above 32 kb limit");
  flash_60k_a: assert property (
    (program_memory_size_select == 8'hCF && addr_c <= 16'hEFFF)
      |=> sel_flash && flash_block <= 6'h3B)
    else $error("60 kb flash not decoded");
  block_number_a: assert property (
    1'b1 |=> flash_block == $past(addr_c[15:10]))
    else $error("block number does not follow address");
  vector_area_a: assert property (
    sel_vector |-> sel_flash && mem_addr <= 16'h003F)
    else $error("vector area outside 0000h to 003fh");
  hsram_area_a: assert property (
    (addr_c >= 16'hFB00 && addr_c <= 16'hFEFF) |=> sel_hsram && !sel_sfr)
    else $error("high speed ram not decoded");
  sfr_page_a: assert property (
    (addr_c[15:8] == 8'hFF) |=> sel_sfr && !sel_hsram && !sel_flash)
    else $error("special register page not decoded");
  boot_block_a: assert property (
    (boot_protect_en && wr_c && flash_c && block_c <= 6'h03)
      |=> write_blocked && !mem_write)
    else $error("boot cluster write not blocked");
  // registered address lags the fetch by one edge after release
  reset_vector_a: assert property (
    $fell(reset) |-> ##1 (mem_addr == 16'h0000 && mem_read)
      ##1 (mem_addr == 16'h0001 && mem_read))
    else $error("reset vector not fetched from 0000h and 0001h");
endmodule // mmvd_decode
`default_nettype wire

// File: hw/mmvd_vector_fetch.sv
// vector table fetch sequencer: reads a 16-bit entry and loads the counter
`timescale 1ns/10ps
`default_nettype none
module mmvd_vector_fetch (
  input wire logic clk,
  input wire logic reset,
  input wire logic irq_accept,
  input wire logic [mmvd_pkg::SLOT_W-1:0] irq_slot,
  input wire logic [7:0] mem_rdata,
  output logic vec_rd,
  output logic [mmvd_pkg::ADDR_W-1:0] vec_addr,
  output logic vec_busy,
  output var logic pc_load,
  output var logic [mmvd_pkg::ADDR_W-1:0] program_counter
);
  import mmvd_pkg::*;

  mmvd_vstate_t state_r, state_nxt;
  logic [SLOT_W-1:0] slot_r, slot_nxt;
  logic [7:0] lo_r, lo_nxt;
  logic pc_load_nxt;
  logic [ADDR_W-1:0] pc_nxt;

  always_comb begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    lo_nxt = lo_r;
    pc_load_nxt = 1'b0;
    pc_nxt = program_counter;
    unique case (state_r)
      ST_IDLE: begin
        // requests during a fetch are dropped; the cpu stalls on busy
        if (irq_accept) begin
          slot_nxt = irq_slot;
          state_nxt = ST_REQ_LO;
        end
      end
      ST_REQ_LO: state_nxt = ST_REQ_HI;
      ST_REQ_HI: state_nxt = ST_TAKE_LO;
      ST_TAKE_LO: begin
        lo_nxt = mem_rdata;
        state_nxt = ST_TAKE_HI;
      end
      ST_TAKE_HI: begin
        pc_nxt = {mem_rdata, lo_r};
        pc_load_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // every reset cause fetches the entry at address zero
      state_r <= ST_REQ_LO;
      slot_r <= SLOT_RESET;
      lo_r <= 8'h00;
      pc_load <= 1'b0;
      program_counter <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      slot_r <= slot_nxt;
      lo_r <= lo_nxt;
      pc_load <= pc_load_nxt;
      program_counter <= pc_nxt;
    end
  end

  assign vec_rd = (state_r == ST_REQ_LO) || (state_r == ST_REQ_HI);
  // even address for the low byte, odd for the high byte
  assign vec_addr = VECTOR_BASE
    | {10'h000, slot_r, (state_r == ST_REQ_HI)};
  assign vec_busy = (state_r != ST_IDLE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence lo_then_hi_s;
    vec_rd && !vec_addr[0] ##1 vec_rd && vec_addr[0];
  endsequence

  vec_pair_order_a: assert property (
    (state_r == ST_REQ_LO) |-> lo_then_hi_s)
    else $error("vector bytes not requested low then high");
  pc_load_timing_a: assert property (
    (state_r == ST_REQ_LO) |-> ##4 pc_load)
    else $error("counter not loaded four cycles after request");
  pc_little_endian_a: assert property (
    (state_r == ST_TAKE_LO) ##1 (state_r == ST_TAKE_HI)
      |=> program_counter == {$past(mem_rdata), $past(mem_rdata, 2)})
    else $error("vector bytes assembled in wrong order");
endmodule // mmvd_vector_fetch
`default_nettype wire

// File: shared/mmvd_pkg.sv
// shared constants and types for the memory map and vector decode
package mmvd_pkg;
  localparam int ADDR_W = 16;
  localparam int SLOT_W = 5;
  localparam int BLOCK_W = 6;
  localparam int BLOCK_LSB = 10;
  // size selection values
  localparam logic [7:0] PROG_SIZE_RESET = 8'hCF;
  localparam logic [7:0] EXP_SIZE_RESET = 8'h0C;
  localparam logic [7:0] PROG_SIZE_32K = 8'hC8;
  localparam logic [7:0] PROG_SIZE_48K = 8'hCC;
  localparam logic [7:0] PROG_SIZE_60K = 8'hCF;
  localparam logic [7:0] EXP_SIZE_1K = 8'h0A;
  localparam logic [7:0] EXP_SIZE_2K = 8'h08;
  // flash limits
  localparam logic [15:0] FLASH_END_32K = 16'h7FFF;
  localparam logic [15:0] FLASH_END_48K = 16'hBFFF;
  localparam logic [15:0] FLASH_END_60K = 16'hEFFF;
  localparam logic [5:0] BLOCK_LAST_32K = 6'h1F;
  localparam logic [5:0] BLOCK_LAST_48K = 6'h2F;
  localparam logic [5:0] BLOCK_LAST_60K = 6'h3B;
  localparam logic [5:0] BOOT_CLUSTER_LAST_BLOCK = 6'h03;
  // data areas
  localparam logic [15:0] EXP_BASE_1K = 16'hF400;
  localparam logic [15:0] EXP_BASE_2K = 16'hF000;
  localparam logic [15:0] EXP_END = 16'hF7FF;
  localparam logic [15:0] HSRAM_BASE = 16'hFB00;
  localparam logic [15:0] HSRAM_END = 16'hFEFF;
  localparam logic [15:0] SFR_BASE = 16'hFF00;
  localparam logic [15:0] VECTOR_BASE = 16'h0000;
  localparam logic [15:0] VECTOR_END = 16'h003F;
  // vector slots, two bytes each
  localparam logic [4:0] SLOT_RESET = 5'h00;
  localparam logic [4:0] SLOT_LOW_VOLTAGE_INTERRUPT = 5'h02;
  localparam logic [4:0] SLOT_EXTERNAL_INTERRUPT_ZERO = 5'h03;
  localparam logic [4:0] SLOT_SOFTWARE_BREAK_VECTOR = 5'h1F;
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_REQ_LO  = 5'b00010,
    ST_REQ_HI  = 5'b00100,
    ST_TAKE_LO = 5'b01000,
    ST_TAKE_HI = 5'b10000
  } mmvd_vstate_t;
endpackage
